/* dv/ctr_top_test.sv */
// Self-checking bench for the cache test register port
// Assumes ctr_top with APB slave, offsets from ctr_regs.svh
`timescale 1ns/1ps
`include "ctr_regs.svh"

module ctr_top_test;
  localparam logic [11:0] D = {8'h00, `CTR_OFF_DATA};
  localparam logic [11:0] S = {8'h00, `CTR_OFF_STATUS};
  localparam logic [11:0] C = {8'h00, `CTR_OFF_CONTROL};

  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        strap = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        wb_mode;
  int          n_fail = 0;
  int          n_tests = 0;

  ctr_top dut_u (
    .clk                (clk),
    .rstn               (rstn),
    .cache_policy_strap (strap),
    .psel               (psel),
    .penable            (penable),
    .pwrite             (pwrite),
    .paddr              (paddr),
    .pwdata             (pwdata),
    .prdata             (prdata),
    .pready             (pready),
    .pslverr            (pslverr),
    .wb_mode            (wb_mode)
  );

  initial begin
    forever #4 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (n_fail == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] cw(input logic [1:0] op, input logic [1:0] ent, input logic [7:0] idx,
                                     input logic [1:0] ss, input logic ext);
    return {12'h000, ext, ss, 1'b0, 4'h0, idx, ent, op};
  endfunction

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
    chk({e, 32'h0}, 33'h0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk({e, q}, {1'b0, x});
  endtask

  task automatic rst(input logic s);
    @(posedge clk);
    rstn <= 1'b0;
    strap <= s;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (6) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Write-through: fill, line write, read back line and status
  task automatic t_wt();
    rst(1'b0);
    chk({32'h0, wb_mode}, 33'h0);
    for (int e = 0; e < 4; e++) begin
      wr(C, cw(2'b00, e[1:0], 8'h5a, 2'b00, 1'b0));
      wr(D, 32'hc0de_0000 + e);
    end
    wr(S, 32'habcd_e7ff);
    rd(S, 32'habcd_e400);
    wr(C, cw(2'b01, 2'b10, 8'h5a, 2'b11, 1'b1));
    rd(C, cw(2'b01, 2'b10, 8'h5a, 2'b00, 1'b0));
    wr(S, 32'h0);
    wr(C, cw(2'b10, 2'b10, 8'h5a, 2'b00, 1'b0));
    rd(S, 32'habcd_e620);
    for (int e = 0; e < 4; e++) begin
      wr(C, cw(2'b00, e[1:0], 8'h5a, 2'b00, 1'b0));
      rd(D, 32'hc0de_0000 + e);
    end
  endtask

  // Write-back: per-way states, both status views, flush
  task automatic t_wb();
    logic [31:0] q;
    logic        e;
    rst(1'b1);
    chk({32'h0, wb_mode}, 33'h1);
    wr(S, 32'h1234_5400);
    rd(S, 32'h1234_5000);
    for (int w = 0; w < 4; w++) begin
      wr(C, cw(2'b01, w[1:0], 8'h33, w[1:0], 1'b0));
    end
    for (int s = 0; s < 4; s++) begin
      wr(C, cw(2'b10, 2'b11, 8'h33, s[1:0], 1'b1));
      rd(S, {1'b0, s[1:0], 29'h0e40_0470});
    end
    rd(C, cw(2'b10, 2'b11, 8'h33, 2'b11, 1'b1));
    wr(C, cw(2'b10, 2'b11, 8'h33, 2'b00, 1'b0));
    rd(S, 32'h1234_5470);
    wr(C, cw(2'b11, 2'b01, 8'h77, 2'b10, 1'b1));
    wr(C, cw(2'b10, 2'b11, 8'h33, 2'b11, 1'b1));
    rd(S, 32'h0);
    apb(1'b0, 12'h00c, 32'h0, q, e);
    chk({e, q}, {1'b1, 32'h0});
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    t_wt();
    t_wb();
    wrap_up();
  end

  initial begin
    #100000;
    n_fail++;
    wrap_up();
  end
endmodule

/* pkg/ctr_pkg.sv */
// Types for the cache test port
// Assumes ctr_regs.svh for widths
`include "ctr_regs.svh"

package ctr_pkg;

  typedef enum logic [1:0] {
    CTR_OP_BUF,
    CTR_OP_WRITE,
    CTR_OP_READ,
    CTR_OP_FLUSH
  } ctr_op_t;

  typedef enum logic [1:0] {
    CTR_ST_INVALID,
    CTR_ST_EXCLUSIVE,
    CTR_ST_MODIFIED,
    CTR_ST_SHARED
  } ctr_mesi_t;

  typedef struct packed {
    logic [2:0]                  sync;
    logic [1:0]                  sync_cnt;
    logic                        strap_done;
    logic                        wb_mode;
    logic                        ctl_ext;
    logic [1:0]                  ctl_ss;
    logic [`CTR_IDX_W-1:0]       ctl_idx;
    logic [1:0]                  ctl_ent;
    ctr_op_t                     ctl_op;
    logic [`CTR_TAG_W-1:0]       st_tag;
    logic                        st_valid;
    logic [2:0]                  st_lru;
    logic [2*`CTR_WAYS-1:0]      st_ways;
    logic [`CTR_LINE_W-1:0]      fill;
    logic [`CTR_LINE_W-1:0]      rbuf;
    logic [`CTR_DW_W-1:0]        prdata;
    logic                        pready;
    logic                        pslverr;
  } ctr_state_t;

endpackage

/* pkg/ctr_regs.svh */
// Register offsets, field positions and geometry for the cache test port
// Assumes a 32-bit APB word per register, byte addresses
`ifndef CTR_REGS_SVH
`define CTR_REGS_SVH

// Register byte offsets (low address bits)
`define CTR_OFF_DATA    4'h0
`define CTR_OFF_STATUS  4'h4
`define CTR_OFF_CONTROL 4'h8

// Control register fields
`define CTR_OP_LSB      0
`define CTR_ENT_LSB     2
`define CTR_IDX_LSB     4
`define CTR_SS_LSB      17
`define CTR_EXT_BIT     19

// Status register fields
`define CTR_VALIDS_LSB  3
`define CTR_LRU_LSB     7
`define CTR_VALID_BIT   10
`define CTR_TAG_LSB     12
`define CTR_ST0_LSB     20
`define CTR_STN_LSB     29

// Geometry
`define CTR_DW_W        32
`define CTR_LINE_W      128
`define CTR_TAG_W       20
`define CTR_IDX_W       8
`define CTR_SETS        256
`define CTR_WAYS        4

// Strap pipe depth before its output is trusted
`define CTR_SYNC_FILL   2'h3

`endif

/* src/ctr_top.sv */
// Cache test register port: data, status and control registers over APB
// Assumes one clock, async active-low reset, policy strap from a pin
`timescale 1ns/1ps
`include "ctr_regs.svh"

module ctr_top #(
  parameter int ADDR_W = 12
) (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              cache_policy_strap,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   wb_mode
);

  if (ADDR_W < 4) begin : g_chk
    $error("ADDR_W must be at least 4");
  end

  ////////////////////////////////////////////////////////////////////////
  // State and memories

  ctr_pkg::ctr_state_t r, n;

  logic [`CTR_LINE_W-1:0]   data_mem [`CTR_SETS*`CTR_WAYS];
  logic [`CTR_TAG_W-1:0]    tag_mem  [`CTR_SETS*`CTR_WAYS];
  logic [2*`CTR_WAYS-1:0]   way_mem  [`CTR_SETS];
  logic [2:0]               lru_mem  [`CTR_SETS];

  logic                     acc;
  logic                     take;
  logic                     hit_data;
  logic                     hit_stat;
  logic                     hit_ctl;
  logic                     ctl_wr;
  logic                     wr_go;
  logic                     rd_go;
  logic                     fl_go;
  logic [`CTR_IDX_W-1:0]    w_idx;
  logic [1:0]               w_ent;
  logic [1:0]               w_ss;
  logic [1:0]               new_state;
  logic [2:0]               lru_upd;
  logic [`CTR_IDX_W+1:0]    line_sel;
  logic [31:0]              rd_val;
  logic [1:0]               selected_way_state;
  logic [2*`CTR_WAYS-1:0]   set_ways;
  logic [`CTR_WAYS-1:0]     way_valid;

  ////////////////////////////////////////////////////////////////////////
  // Bus decode

  assign acc      = psel & penable;
  assign take     = acc & r.pready;
  assign hit_data = (paddr[3:0] == `CTR_OFF_DATA)    && (paddr >> 4) == '0;
  assign hit_stat = (paddr[3:0] == `CTR_OFF_STATUS)  && (paddr >> 4) == '0;
  assign hit_ctl  = (paddr[3:0] == `CTR_OFF_CONTROL) && (paddr >> 4) == '0;
  assign ctl_wr   = take & pwrite & hit_ctl;

  // Operation decode from the written control word
  assign w_idx    = pwdata[`CTR_IDX_LSB +: `CTR_IDX_W];
  assign w_ent    = pwdata[`CTR_ENT_LSB +: 2];
  assign w_ss     = pwdata[`CTR_SS_LSB +: 2];
  assign rd_go    = ctl_wr && pwdata[`CTR_OP_LSB +: 2] == ctr_pkg::CTR_OP_READ;
  assign wr_go    = ctl_wr && pwdata[`CTR_OP_LSB +: 2] == ctr_pkg::CTR_OP_WRITE;
  assign fl_go    = ctl_wr && pwdata[`CTR_OP_LSB +: 2] == ctr_pkg::CTR_OP_FLUSH;
  assign line_sel = {w_idx, w_ent};
  assign set_ways = way_mem[w_idx];

  // New way state: field in write-back, valid bit in write-through
  assign new_state = r.wb_mode ? w_ss : {1'b0, r.st_valid};

  // Pseudo-LRU touch for the written way
  always_comb begin
    lru_upd    = lru_mem[w_idx];
    lru_upd[0] = (w_ent < 2'h2);
    if (w_ent < 2'h2) begin
      lru_upd[1] = (w_ent == 2'h0);
    end else begin
      lru_upd[2] = (w_ent == 2'h2);
    end
  end

  // Selected-way state view
  assign selected_way_state = r.st_ways[2*r.ctl_ss +: 2];

  // Per-way valid view
  for (genvar g = 0; g < `CTR_WAYS; g++) begin : g_way
    assign way_valid[g] = r.st_ways[2*g +: 2] != ctr_pkg::CTR_ST_INVALID;
  end

  ////////////////////////////////////////////////////////////////////////
  // Read mux

  always_comb begin
    rd_val = '0;
    if (hit_data) begin
      rd_val = r.rbuf[32*r.ctl_ent +: 32];
    end else if (hit_stat) begin
      rd_val[`CTR_VALID_BIT] = r.st_valid;
      rd_val[`CTR_LRU_LSB +: 3] = r.st_lru;
      rd_val[`CTR_VALIDS_LSB +: `CTR_WAYS] = way_valid;
      if (r.wb_mode && r.ctl_ext) begin
        rd_val[`CTR_STN_LSB +: 2] = selected_way_state;
        rd_val[`CTR_ST0_LSB +: 8] = r.st_ways;
      end else begin
        rd_val[`CTR_TAG_LSB +: `CTR_TAG_W] = r.st_tag;
      end
    end else if (hit_ctl) begin
      rd_val[`CTR_OP_LSB +: 2]          = r.ctl_op;
      rd_val[`CTR_ENT_LSB +: 2]         = r.ctl_ent;
      rd_val[`CTR_IDX_LSB +: `CTR_IDX_W] = r.ctl_idx;
      rd_val[`CTR_SS_LSB +: 2]          = r.ctl_ss;
      rd_val[`CTR_EXT_BIT]              = r.ctl_ext;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    n = r;
    // Strap capture after reset release
    n.sync = {r.sync[1:0], cache_policy_strap};
    if (r.sync_cnt != `CTR_SYNC_FILL) begin
      n.sync_cnt = r.sync_cnt + 2'h1;
    end
    if (!r.strap_done && r.sync_cnt == `CTR_SYNC_FILL && r.sync[1] == r.sync[2]) begin
      n.wb_mode    = r.sync[2];
      n.strap_done = 1'b1;
    end
    // Answer one cycle into the access phase
    n.pready  = acc & ~r.pready;
    n.pslverr = acc & ~r.pready & ~(hit_data | hit_stat | hit_ctl);
    n.prdata  = (acc & ~r.pready & ~pwrite) ? rd_val : '0;
    if (take && pwrite && hit_data && r.ctl_op == ctr_pkg::CTR_OP_BUF) begin
      n.fill[32*r.ctl_ent +: 32] = pwdata;
    end
    if (take && pwrite && hit_stat) begin
      if (!r.wb_mode || !r.ctl_ext) begin
        n.st_tag = pwdata[`CTR_TAG_LSB +: `CTR_TAG_W];
      end
      if (!r.wb_mode) begin
        n.st_valid = pwdata[`CTR_VALID_BIT];
      end
    end
    if (ctl_wr) begin
      n.ctl_op  = ctr_pkg::ctr_op_t'(pwdata[`CTR_OP_LSB +: 2]);
      n.ctl_ent = w_ent;
      n.ctl_idx = w_idx;
      n.ctl_ss  = r.wb_mode ? w_ss : 2'h0;
      n.ctl_ext = r.wb_mode & pwdata[`CTR_EXT_BIT];
    end
    if (rd_go) begin
      n.rbuf     = data_mem[line_sel];
      n.st_tag   = tag_mem[line_sel];
      n.st_lru   = lru_mem[w_idx];
      n.st_ways  = set_ways;
      n.st_valid = set_ways[2*w_ent +: 2] != ctr_pkg::CTR_ST_INVALID;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Cache arrays

  always_ff @(posedge clk) begin
    if (wr_go) begin
      data_mem[line_sel] <= r.fill;
      tag_mem[line_sel]  <= r.st_tag;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int s = 0; s < `CTR_SETS; s++) begin
        way_mem[s] <= '0;
        lru_mem[s] <= '0;
      end
    end else if (fl_go) begin
      for (int s = 0; s < `CTR_SETS; s++) begin
        way_mem[s] <= '0;
        lru_mem[s] <= '0;
      end
    end else if (wr_go) begin
      way_mem[w_idx][2*w_ent +: 2] <= new_state;
      lru_mem[w_idx]               <= lru_upd;
    end
  end

  assign prdata  = r.prdata;
  assign pready  = r.pready;
  assign pslverr = r.pslverr;
  assign wb_mode = r.wb_mode;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  ready_one_cycle_a: assert property (
    pready
    |=> !pready)
    else $error("pready held");

  ready_follows_a: assert property (
    psel && penable && !pready
    |=> pready)
    else $error("no answer after access");

  err_with_ready_a: assert property (
    pslverr
    |-> pready)
    else $error("error without ready");

  data_idle_zero_a: assert property (
    !pready
    |-> prdata == '0)
    else $error("read data outside answer");

  unmapped_err_a: assert property (
    psel && penable && !pready && !(hit_data || hit_stat || hit_ctl)
    |=> pslverr)
    else $error("unmapped access not refused");

  mode_held_a: assert property (
    r.strap_done
    |=> $stable(r.wb_mode) && r.strap_done)
    else $error("policy changed");

  strap_capture_a: assert property (
    !r.strap_done && r.sync_cnt == `CTR_SYNC_FILL && r.sync[1] == r.sync[2]
    |=> r.strap_done && r.wb_mode == $past(r.sync[2]))
    else $error("policy not captured");

  ext_wt_zero_a: assert property (
    !r.wb_mode
    |-> !r.ctl_ext && r.ctl_ss == 2'h0)
    else $error("ext set in write-through");

  wb_ctl_capture_a: assert property (
    ctl_wr && r.wb_mode
    |=> r.ctl_ss == $past(w_ss) && r.ctl_ext == $past(pwdata[`CTR_EXT_BIT]))
    else $error("ext or set state not captured");

  op_capture_a: assert property (
    ctl_wr
    |=> r.ctl_op == $past(pwdata[`CTR_OP_LSB +: 2]))
    else $error("operation not captured");

  ctl_capture_a: assert property (
    ctl_wr
    |=> r.ctl_idx == $past(w_idx) && r.ctl_ent == $past(w_ent))
    else $error("index or entry not captured");

  data_read_a: assert property (
    psel && penable && !pready && !pwrite && hit_data
    |=> prdata == $past(r.rbuf[32*r.ctl_ent +: 32]))
    else $error("read buffer slot wrong");

  stat_ext_view_a: assert property (
    psel && penable && !pready && !pwrite && hit_stat && r.wb_mode && r.ctl_ext
    |=> prdata[`CTR_STN_LSB +: 2] == $past(selected_way_state))
    else $error("selected state wrong");

  read_loads_a: assert property (
    rd_go
    |=> r.st_lru == $past(lru_mem[w_idx]) && r.st_ways == $past(set_ways))
    else $error("read did not load status");

  read_line_a: assert property (
    rd_go
    |=> r.rbuf == $past(data_mem[line_sel]) && r.st_tag == $past(tag_mem[line_sel]))
    else $error("read did not load line");

  read_valid_a: assert property (
    rd_go
    |=> r.st_valid == (r.st_ways[2*$past(w_ent) +: 2] != ctr_pkg::CTR_ST_INVALID))
    else $error("valid bit not loaded");

  read_no_lru_a: assert property (
    rd_go
    |=> lru_mem[$past(w_idx)] == $past(lru_mem[w_idx]))
    else $error("read touched LRU");

  fill_store_a: assert property (
    take && pwrite && hit_data && r.ctl_op == ctr_pkg::CTR_OP_BUF
    |=> r.fill[32*$past(r.ctl_ent) +: 32] == $past(pwdata))
    else $error("fill slot wrong");

  tag_write_a: assert property (
    take && pwrite && hit_stat && !(r.wb_mode && r.ctl_ext)
    |=> r.st_tag == $past(pwdata[`CTR_TAG_LSB +: `CTR_TAG_W]))
    else $error("tag not written");

  wt_valid_write_a: assert property (
    take && pwrite && hit_stat && !r.wb_mode
    |=> r.st_valid == $past(pwdata[`CTR_VALID_BIT]))
    else $error("valid not taken");

  wb_valid_hold_a: assert property (
    take && pwrite && hit_stat && r.wb_mode
    |=> $stable(r.st_valid))
    else $error("valid written in write-back");

  lru_ro_a: assert property (
    take && pwrite && hit_stat
    |=> $stable(r.st_lru))
    else $error("LRU written");

  line_write_a: assert property (
    wr_go
    |=> data_mem[$past(line_sel)] == $past(r.fill) && tag_mem[$past(line_sel)] == $past(r.st_tag))
    else $error("line not stored");

  wb_state_a: assert property (
    wr_go && r.wb_mode
    |=> way_mem[$past(w_idx)][2*$past(w_ent) +: 2] == $past(w_ss))
    else $error("state not set");

  wt_valid_a: assert property (
    wr_go && !r.wb_mode
    |=> way_mem[$past(w_idx)][2*$past(w_ent) +: 2] == {1'b0, $past(r.st_valid)})
    else $error("valid not written");

  lru_low_a: assert property (
    wr_go && w_ent < 2'h2
    |=> lru_mem[$past(w_idx)][0] && lru_mem[$past(w_idx)][1] == ($past(w_ent) == 2'h0))
    else $error("LRU low pair not touched");

  lru_high_a: assert property (
    wr_go && w_ent >= 2'h2
    |=> !lru_mem[$past(w_idx)][0] && lru_mem[$past(w_idx)][2] == ($past(w_ent) == 2'h2))
    else $error("LRU high pair not touched");

  flush_clear_a: assert property (
    fl_go
    |=> way_mem[$past(w_idx)] == '0 && lru_mem[0] == '0 && lru_mem[`CTR_SETS-1] == '0)
    else $error("flush left state");

endmodule
